// [src/spp_core.sv]
// Synchronous serial port, SPI mode: control, status, data buffer, shifter.
// Assumes pins are sampled through spp_sync; register port is on mclk.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps

// Function
// - Each transfer shifts eight bits out and eight in at once.
// - All four clock polarity and phase combinations are supported.
// - Data out, data in and clock lines; slave select optional in slave.
// - Control register one is fully readable and writable.
// - Status low six bits read-only, top two bits read and write.
// - Complete word copied into holding buffer unless it overflows; interrupt flag set.
// - Data write in idle loads buffer and shift register together.
module spp_core (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       sdi_in,
  output logic            sdo_out,
  output logic            sdo_oe,
  input  wire logic       ss_n_in
);

  // ****************************************
  // Declarations
  // ****************************************
  spp_pkg::spp_control_t control_one;
  spp_pkg::spp_pins_t    pins_raw;
  spp_pkg::spp_pins_t    pins;
  spp_pkg::spp_state_t   state;
  logic [7:0]            data_buffer;
  logic [7:0]            shift_reg;
  logic [7:0]            next_shift;
  logic                  buffer_full;
  logic                  sample_phase_sel;
  logic                  clock_edge_sel;
  logic [7:0]            irq_status;
  logic [7:0]            irq_mask;
  logic [7:0]            half_count;
  logic [7:0]            half_len;
  logic [4:0]            step;
  logic                  sck_prev;
  logic                  is_master;
  logic                  slave_sel;
  logic                  selected;
  logic                  step_tick;
  logic                  slave_edge;
  logic                  master_tick;
  logic                  sample_now;
  logic                  change_now;
  logic                  word_done;
  logic                  wr_ctrl;
  logic                  wr_stat;
  logic                  wr_data;
  logic                  rd_data;
  logic                  collision_ev;
  logic                  overflow_ev;
  logic [4:0]            last_step;

  // ****************************************
  // Pin sampling
  // ****************************************
  // Raw pins never reach logic before two flops
  assign pins_raw.sck  = sck_in;
  assign pins_raw.serial_in_line  = sdi_in;
  assign pins_raw.ss_n = ss_n_in;

  spp_sync #(.W(3)) u_sync (.mclk(mclk), .rst_n(rst_n), .d(pins_raw), .q(pins));

  // ****************************************
  // Register port decode
  // ****************************************
  assign wr_ctrl = reg_wr && (reg_addr == spp_pkg::ADDR_CONTROL_ONE);
  assign wr_stat = reg_wr && (reg_addr == spp_pkg::ADDR_STATUS);
  assign wr_data = reg_wr && (reg_addr == spp_pkg::ADDR_DATA_BUFFER);
  assign rd_data = reg_rd && (reg_addr == spp_pkg::ADDR_DATA_BUFFER);

  // ****************************************
  // Mode decode
  // ****************************************
  assign is_master = (control_one.mode <= spp_pkg::MODE_MASTER_SLOW); // Rates take the low codes
  assign slave_sel = (control_one.mode == spp_pkg::MODE_SLAVE_SELECT);
  // Select input only qualifies slave transfers in that one mode
  assign selected  = !slave_sel || !pins.ss_n;

  // Half serial clock length per master rate
  always_comb begin
    unique case (control_one.mode)
      spp_pkg::MODE_MASTER_DIV4:  half_len = spp_pkg::HALF_DIV4;
      spp_pkg::MODE_MASTER_DIV16: half_len = spp_pkg::HALF_DIV16;
      spp_pkg::MODE_MASTER_DIV64: half_len = spp_pkg::HALF_DIV64;
      default:                    half_len = spp_pkg::HALF_SLOW;
    endcase
  end

  // ****************************************
  // Edge step generation
  // ****************************************
  // Master: one enable pulse per half serial clock from the divider
  assign master_tick = is_master && (state == spp_pkg::ST_SHIFT)
                    && (half_count == half_len - 8'h01);
  // Slave: edge found by comparing the synced clock with its last value
  assign slave_edge  = !is_master && (state == spp_pkg::ST_SHIFT)
                    && selected && (pins.sck != sck_prev);
  assign step_tick   = master_tick || slave_edge;

  // Sample-phase only honoured as master; slave must keep it clear
  assign last_step = (is_master && sample_phase_sel) ?
                     spp_pkg::LAST_EDGE + 5'h01 : spp_pkg::LAST_EDGE;

  // Even steps lead away from idle, odd steps return to idle.
  // Edge-select set: data changes on return to idle, sampled on leading.
  always_comb begin
    sample_now = 1'b0;
    change_now = 1'b0;
    if (step_tick) begin
      if (is_master && sample_phase_sel) begin // Late: end of the bit time
        sample_now = (step != 5'h00) && (step[0] == clock_edge_sel);
      end else begin
        sample_now = (step[0] != clock_edge_sel);
      end
      change_now = (step < spp_pkg::LAST_EDGE) && (step[0] == clock_edge_sel);
    end
  end

  // Shifter moves one bit per sample, MSB first
  assign next_shift = sample_now ? {shift_reg[6:0], pins.serial_in_line} : shift_reg;
  assign word_done  = step_tick && (step == last_step);

  // Collision: write while a word is in flight; overflow: full on arrival
  assign collision_ev = wr_data && (state != spp_pkg::ST_IDLE);
  assign overflow_ev  = word_done && buffer_full && !rd_data;

  // ****************************************
  // Divider for the master clock
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      half_count <= 8'h00;
    end else if (!is_master || state != spp_pkg::ST_SHIFT || master_tick) begin
      half_count <= 8'h00;
    end else begin
      half_count <= half_count + 8'h01;
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // Slave stays in shift waiting for edges; word ends after 16 edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= spp_pkg::ST_IDLE;
      step  <= 5'h00;
    end else if (!control_one.enable) begin
      state <= spp_pkg::ST_IDLE;
      step  <= 5'h00;
    end else begin
      unique case (state)
        spp_pkg::ST_IDLE: begin
          step <= 5'h00;
          if (wr_data) begin
            state <= spp_pkg::ST_SHIFT;
          end
        end
        spp_pkg::ST_SHIFT: begin
          if (slave_sel && pins.ss_n) begin
            // Deselect mid-word discards the partial count
            step <= 5'h00;
          end else if (word_done) begin
            state <= spp_pkg::ST_DONE;
            step  <= 5'h00;
          end else if (step_tick) begin
            step <= step + 5'h01;
          end
        end
        spp_pkg::ST_DONE: state <= spp_pkg::ST_IDLE;
        default:          state <= spp_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Shift register and data buffer
  // ****************************************
  // Transmit is single-buffered: a write lands in both at once
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
    end else if (wr_data && state == spp_pkg::ST_IDLE) begin
      shift_reg <= reg_wdata;
    end else begin
      shift_reg <= next_shift;
    end
  end

  // Holding buffer keeps the last word; overflow drops the new one
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_buffer <= 8'h00;
    end else if (wr_data && state == spp_pkg::ST_IDLE) begin
      data_buffer <= reg_wdata;
    end else if (word_done && !overflow_ev) begin
      data_buffer <= next_shift;
    end
  end

  // Arrival wins over a read in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buffer_full <= 1'b0;
    end else if (word_done) begin
      buffer_full <= 1'b1;
    end else if (rd_data) begin
      buffer_full <= 1'b0;
    end
  end

  // ****************************************
  // Control register one and status top bits
  // ****************************************
  // Hardware sets of the flag bits win over a software write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_one <= spp_pkg::RESET_CONTROL_ONE;
    end else begin
      if (wr_ctrl) begin
        control_one <= reg_wdata;
      end
      if (collision_ev) begin
        control_one.collision <= 1'b1;
      end
      if (overflow_ev) begin
        control_one.overflow <= 1'b1;
      end
    end
  end

  // Only bits 7 and 6 take a write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sample_phase_sel <= spp_pkg::RESET_STATUS[spp_pkg::STAT_SAMPLE_PHASE];
      clock_edge_sel   <= spp_pkg::RESET_STATUS[spp_pkg::STAT_CLOCK_EDGE];
    end else if (wr_stat) begin
      sample_phase_sel <= reg_wdata[spp_pkg::STAT_SAMPLE_PHASE];
      clock_edge_sel   <= reg_wdata[spp_pkg::STAT_CLOCK_EDGE];
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Write one to clear; an event in the same cycle keeps its bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_status <= spp_pkg::RESET_IRQ;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (reg_wr && reg_addr == spp_pkg::ADDR_IRQ_STATUS && reg_wdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (word_done) begin
        irq_status[spp_pkg::IRQ_WORD_DONE] <= 1'b1;
      end
      if (collision_ev) begin
        irq_status[spp_pkg::IRQ_COLLISION] <= 1'b1;
      end
      if (overflow_ev) begin
        irq_status[spp_pkg::IRQ_OVERFLOW] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_mask <= spp_pkg::RESET_IRQ;
    end else if (reg_wr && reg_addr == spp_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= reg_wdata;
    end
  end

  // Registered level; lags the status bit by one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        spp_pkg::ADDR_CONTROL_ONE: reg_rdata <= control_one;
        spp_pkg::ADDR_STATUS:
          reg_rdata <= {sample_phase_sel, clock_edge_sel, 5'h00, buffer_full};
        spp_pkg::ADDR_DATA_BUFFER: reg_rdata <= data_buffer;
        spp_pkg::ADDR_IRQ_STATUS:  reg_rdata <= irq_status;
        spp_pkg::ADDR_IRQ_MASK:    reg_rdata <= irq_mask;
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Serial pins
  // ****************************************
  // Previous synced clock, for slave edge finding
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pins.sck;
    end
  end

  // Master clock toggles on each of the 16 edge steps, idles at polarity
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else begin
      sck_oe <= control_one.enable && is_master;
      if (!is_master || state != spp_pkg::ST_SHIFT) begin
        sck_out <= control_one.clock_idle_polarity;
      end else if (master_tick && step <= spp_pkg::LAST_EDGE) begin
        sck_out <= ~sck_out;
      end
    end
  end

  // Data out: first bit ready at load, later bits on the change edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      sdo_oe <= control_one.enable && selected;
      if (wr_data && state == spp_pkg::ST_IDLE) begin
        sdo_out <= reg_wdata[7];
      end else if (change_now) begin
        sdo_out <= next_shift[7];
      end
    end
  end

endmodule

// [src/spp_pkg.sv]
// Package for the synchronous serial port in shift-register (SPI) mode.
// Assumes one 100 MHz clock and an 8-bit register port with 3 address bits.
package spp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
  localparam logic [2:0] ADDR_STATUS      = 3'h1;
  localparam logic [2:0] ADDR_DATA_BUFFER = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK    = 3'h4;

  localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RESET_STATUS      = 8'h00;
  localparam logic [7:0] RESET_IRQ         = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STAT_SAMPLE_PHASE = 7;
  localparam int STAT_CLOCK_EDGE   = 6;
  localparam int STAT_BUFFER_FULL  = 0;

  localparam int IRQ_WORD_DONE = 0;
  localparam int IRQ_COLLISION = 1;
  localparam int IRQ_OVERFLOW  = 2;

  localparam int WORD_BITS = 8;

  // ****************************************
  // Modes of the low control nibble
  // ****************************************
  localparam logic [3:0] MODE_MASTER_DIV4   = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16  = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64  = 4'h2;
  localparam logic [3:0] MODE_MASTER_SLOW   = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SELECT  = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NO_SEL  = 4'h5;

  // ****************************************
  // Timing: half serial clock periods in mclk cycles
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_DIV4_NS   = 40;
  localparam int SCK_DIV16_NS  = 160;
  localparam int SCK_DIV64_NS  = 640;
  localparam int SCK_SLOW_NS   = 2560;
  localparam logic [7:0] HALF_DIV4  = 8'(SCK_DIV4_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] HALF_DIV16 = 8'(SCK_DIV16_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] HALF_DIV64 = 8'(SCK_DIV64_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] HALF_SLOW  = 8'(SCK_SLOW_NS / (2 * CLK_PERIOD_NS));

  // Last step of a word: 16 clock edges, one more when sampling late
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       collision;
    logic       overflow;
    logic       enable;
    logic       clock_idle_polarity;
    logic [3:0] mode;
  } spp_control_t;

  typedef struct packed {
    logic sck;
    logic serial_in_line;
    logic ss_n;
  } spp_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } spp_state_t;

endpackage

// [src/spp_sync.sv]
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level from outside the mclk domain.
`timescale 1ns/100ps
module spp_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // ****************************************
  // Two stages; only the second reads the first
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// [verification/spp_core_chk.sv]
// Checker for spp_core: register port and serial pin relations.
// Assumes a bind to spp_core; sees its ports only.
`timescale 1ns/100ps
module spp_core_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq,
  input wire logic       sck_in,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       sdi_in,
  input wire logic       sdo_out,
  input wire logic       sdo_oe,
  input wire logic       ss_n_in
);
  localparam logic [2:0] A_CTL = spp_pkg::ADDR_CONTROL_ONE;
  localparam logic [2:0] A_ST  = spp_pkg::ADDR_STATUS;
  localparam logic [2:0] A_DAT = spp_pkg::ADDR_DATA_BUFFER;
  localparam logic [2:0] A_IM  = spp_pkg::ADDR_IRQ_MASK;
  // ************************
  // Register port and pins
  // ************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Read data stands only in the answer cycle
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_status_zero: assert property ($past(reg_rd) && $past(reg_addr) == A_ST
    |-> reg_rdata[5:1] == 5'h00) else $error("unused status bits not zero");
  a_ctrl_rw: assert property ((reg_wr && reg_addr == A_CTL ##1
    reg_rd && reg_addr == A_CTL) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control readback differs");
  a_status_rw: assert property ((reg_wr && reg_addr == A_ST ##1
    reg_rd && reg_addr == A_ST) |=> reg_rdata[7:6] == 2'($past(reg_wdata, 2) >> 6))
    else $error("status top bits readback differs");
  // A buffer read leaves no word waiting
  a_bf_cleared: assert property ((reg_rd && reg_addr == A_DAT ##1
    reg_rd && reg_addr == A_ST) |=> !reg_rdata[0]) else $error("full flag kept");
  a_slave_no_sck: assert property (reg_wr && reg_addr == A_CTL
    && reg_wdata[3:2] == 2'b01 |-> ##2 !sck_oe) else $error("slave drives clock");
  a_idle_level: assert property (reg_wr && reg_addr == A_CTL |-> ##2
    {7'h00, sck_out} == (($past(reg_wdata, 2) >> 4) & 8'h01))
    else $error("clock idle level wrong");
  a_mask_off: assert property (reg_wr && reg_addr == A_IM && reg_wdata == 8'h00
    |-> ##2 !irq) else $error("irq while masked");
  // Shortest half period is two cycles
  a_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
    else $error("clock half period too short");
endmodule

bind spp_core spp_core_chk chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi_in),
  .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_in(ss_n_in));

// [verification/spp_far_end.sv]
// Far-end model: SPI peripheral, or master when the core is a slave.
// Assumes the bench merges both clock drivers into one line.
`timescale 1ns/100ps
module spp_far_end (
  input  wire logic sck_line,
  input  wire logic sdo_line,
  input  wire logic cpol,
  input  wire logic cke,
  output logic      sck_drv,
  output logic      serial_in_line
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic       seen = 1'b0;
  initial sck_drv = 1'b0;
  assign serial_in_line = tx[7];
  // ************************
  // Shifting on line edges
  // ************************
  // First bit held until one sample; released line keeps moving
  always @(sck_line) begin
    if ((sck_line != cpol) === cke) begin
      rx <= {rx[6:0], sdo_line};
      seen <= 1'b1;
    end else if (seen) begin
      tx <= {tx[6:0], ~tx[7]};
    end
  end
  // Idle level first, so its edge lands before the word is set
  task automatic load(input logic [7:0] b, input logic pol);
    sck_drv = pol;
    #1;
    tx = b;
    rx = 8'h00;
    seen = 1'b0;
  endtask
  // Clock runs only within a frame, 125 ns period
  task automatic run_clock();
    repeat (16) begin
      #62.5;
      sck_drv = ~sck_drv;
    end
    #62.5;
  endtask
endmodule

// [verification/tb_top.sv]
// Bench for spp_core: register tasks, far-end model, transfer checks.
// Assumes package, core, sync, checker and far-end model compiled first.
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] A_CTL = spp_pkg::ADDR_CONTROL_ONE;
  localparam logic [2:0] A_ST  = spp_pkg::ADDR_STATUS;
  localparam logic [2:0] A_DAT = spp_pkg::ADDR_DATA_BUFFER;
  localparam logic [2:0] A_IS  = spp_pkg::ADDR_IRQ_STATUS;
  localparam logic [2:0] A_IM  = spp_pkg::ADDR_IRQ_MASK;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ss_n = 1'b1;
  logic       pol = 1'b0;
  logic       cke = 1'b0;
  logic [7:0] reg_rdata;
  logic       irq, sck_out, sck_oe, sdo_out, sdo_oe, sck_drv, serial_in_line;
  wire logic  sck_line = sck_oe ? sck_out : sck_drv;
  wire logic  sdo_line = sdo_oe ? sdo_out : 1'bz;
  int         err_count = 0;
  int         check_count = 0;
  // Entries {sample phase, idle polarity, edge select, mode}
  // Fastest rate samples late: mid-bit, the synced input is still stale
  logic [6:0] cfg [7] = '{7'h01, 7'h51, 7'h62, 7'h33, 7'h50, 7'h15, 7'h24};
  always #5 mclk = ~mclk;
  spp_core dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_line),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(serial_in_line), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .ss_n_in(ss_n));
  spp_far_end pr_u (.sck_line(sck_line), .sdo_line(sdo_line), .cpol(pol), .cke(cke),
    .sck_drv(sck_drv), .serial_in_line(serial_in_line));
  // ************************
  // Register port tasks
  // ************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Strobes stay up until the next call, so calls run back to back
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic idle();
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    idle();
  endtask
  task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    idle();
    chk(n, e, reg_rdata);
  endtask
  task automatic wrc(input string n, input logic [2:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    bus(1'b1, a, d);
    rdc(n, a, e);
  endtask
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    if (irq !== 1'b1) begin
      err_count++;
      $display("mismatch irq expected 1 seen %b", irq);
      print_verdict();
    end
  endtask
  // ************************
  // Main sequence
  // ************************
  initial begin
    logic [7:0] txb;
    logic [7:0] v1;
    logic [6:0] c;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rdc("reset value", 3'(a), 8'h00);
    wr(3'h6, 8'hff);
    rdc("unmapped", 3'h6, 8'h00);
    $display("test reset done");
    wrc("control", A_CTL, 8'hcb, 8'hcb);
    wrc("control", A_CTL, 8'h14, 8'h14);
    wrc("status", A_ST, 8'hff, 8'hc0);
    wrc("status", A_ST, 8'h41, 8'h40);
    $display("test registers done");
    // Every mode and every polarity and edge pairing
    for (int i = 0; i < 7; i++) begin
      c = cfg[i];
      txb = 8'(8'ha5 ^ (8'h11 * i));
      pol <= c[5];
      cke <= c[4];
      ss_n <= 1'b1;
      wr(A_ST, {c[6], c[4], 6'h00});
      wr(A_CTL, {2'b00, 1'b1, c[5], c[3:0]});
      wr(A_IM, 8'h01);
      pr_u.load(~txb, c[5]);
      wr(A_DAT, txb);
      if (c[3:0] == spp_pkg::MODE_SLAVE_SELECT) begin
        pr_u.run_clock();
        rdc("deselected", A_IS, 8'h00);
        chk("sdo enable", 8'h00, {7'h00, sdo_oe});
        ss_n <= 1'b0;
        pr_u.load(~txb, c[5]);
      end
      if (c[2]) pr_u.run_clock();
      wait_irq();
      chk("far end rx", txb, pr_u.rx);
      rdc("full status", A_ST, {c[6], c[4], 6'h01});
      rdc("irq status", A_IS, 8'h01);
      // Buffer read, then status right behind it
      bus(1'b0, A_DAT, 8'h00);
      bus(1'b0, A_ST, 8'h00);
      #1;
      v1 = reg_rdata;
      idle();
      chk("holding buffer", ~txb, v1);
      chk("status after read", {c[6], c[4], 6'h00}, reg_rdata);
      wr(A_IS, 8'hff);
      rdc("irq cleared", A_IS, 8'h00);
      chk("irq low", 8'h00, {7'h00, irq});
      $display("test transfer %0d done", i);
    end
    pol <= 1'b0;
    wr(A_CTL, 8'h21);
    pr_u.load(8'h3c, 1'b0);
    wr(A_DAT, 8'h96);
    wr(A_DAT, 8'h69);
    wait_irq();
    chk("collision rx", 8'h96, pr_u.rx);
    rdc("collision flag", A_CTL, 8'ha1);
    rdc("irq status", A_IS, 8'h03);
    wr(A_IM, 8'h00);
    rdc("mask off", A_IM, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(A_IM, 8'h01);
    rdc("mask on", A_IM, 8'h01);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    $display("test collision done");
    // Buffer still full from the last word: next arrival overflows
    wr(A_IS, 8'hff);
    pr_u.load(8'hc3, 1'b0);
    wr(A_DAT, 8'h5a);
    wait_irq();
    chk("overflow rx", 8'h5a, pr_u.rx);
    rdc("overflow flag", A_CTL, 8'he1);
    rdc("overflow irq", A_IS, 8'h05);
    rdc("kept buffer", A_DAT, 8'h5a);
    $display("test overflow done");
    print_verdict();
  end
endmodule
